// ===== bct_defs.vh
// Constants for the boost control register bank: offsets, field positions, reset values.
// Assumes inclusion by bare name from the design files of this block.
`ifndef BCT_DEFS_VH
`define BCT_DEFS_VH
// Register indices (printed offsets); byte address is four times these
`define BCT_IDX_CTRL 8'h00
`define BCT_IDX_BOOST2 8'h22
`define BCT_IDX_SEL 8'h21
`define BCT_IDX_SINK 8'h30
// Field positions in boost_control_two
`define BCT_B_GAIN 0
`define BCT_B_ELEV 1
`define BCT_B_FBOV 2
`define BCT_B_COIL 3
`define BCT_B_GA 4
`define BCT_B_GB 5
`define BCT_B_GC 6
`define BCT_B_AUTO 7
// Control register field
`define BCT_B_BOOST_EN 3
// Reset values
`define BCT_RST_BOOST2 8'h0c
`define BCT_RST_CTRL 8'h00
`define BCT_RST_SEL 8'h00
`define BCT_RST_SINK 8'h00
// Feedback source codes
`define BCT_FB_PIN 2'h0
`define BCT_FB_A 2'h1
`define BCT_FB_B 2'h2
`define BCT_FB_C 2'h3
`endif

// ===== bct_sink_guard.v
// One high-voltage sink: overvoltage pull-down and auto-feedback eligibility.
// Assumes comparator input already synchronised by the caller.
module bct_sink_guard
(
  input wire pclk,
  input wire presetn,
  input wire guard_en,
  input wire boost_en,
  input wire over_v,
  input wire [1:0] mode,
  input wire on_pump,
  output reg pull_on,
  output wire eligible
);
  // ==========================================
  // Pull-down control
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pull_on <= 1'b0;
    else
      pull_on <= guard_en & boost_en & over_v;
  end

  assign eligible = (mode != 2'h0) & ~on_pump;
endmodule // bct_sink_guard

// ===== bct_boost_regs.v
// APB register bank for the boost converter settings and feedback selection.
// Assumes a single 50 MHz APB clock; comparator inputs are asynchronous.
// Assumes the analog side reads every configuration output as a static level.
`include "bct_defs.vh"

module bct_boost_regs
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [2:0] sink_over_v,
  output reg boost_enable,
  output reg gain_select,
  output reg light_load_elevate,
  output reg feedback_overvoltage_guard,
  output reg coil_limit_reduce,
  output reg [2:0] sink_pulldown,
  output reg [1:0] fb_source,
  output reg fb_from_pin
);
  // ==========================================
  // Register storage
  localparam NUM_SINKS = 3;
  reg [7:0] ctrl;
  reg [7:0] boost2;
  reg [7:0] sel;
  reg [7:0] sink_cfg;
  wire [1:0] feedback_source_sel;
  wire auto_feedback_pick;
  wire [5:0] sink_mode_field;
  wire [2:0] sink_on_pump_flag;

  assign feedback_source_sel = sel[2:1];
  assign auto_feedback_pick = boost2[`BCT_B_AUTO];
  assign sink_mode_field = {sink_cfg[5:4], sink_cfg[3:2], sink_cfg[1:0]};
  // Sink a has no pump-connection bit in this model, so it never counts as on the pump
  assign sink_on_pump_flag = {sink_cfg[7], sink_cfg[6], 1'b0};

  // ==========================================
  // Pin synchronisers
  // Two flops per comparator: the pins move with no regard to pclk
  reg [2:0] ov_s1;
  reg [2:0] ov_s2;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ov_s1 <= 3'h0;
      ov_s2 <= 3'h0;
    end
    else
    begin
      ov_s1 <= sink_over_v;
      ov_s2 <= ov_s1;
    end
  end

  // ==========================================
  // APB slave: zero wait states, unmapped address gives pslverr
  wire [9:0] widx;
  wire hit_ctrl;
  wire hit_b2;
  wire hit_sel;
  wire hit_sink;
  wire mapped;
  wire acc;
  assign widx = paddr[11:2];
  assign hit_ctrl = (widx == {2'h0, `BCT_IDX_CTRL});
  assign hit_b2 = (widx == {2'h0, `BCT_IDX_BOOST2});
  assign hit_sel = (widx == {2'h0, `BCT_IDX_SEL});
  assign hit_sink = (widx == {2'h0, `BCT_IDX_SINK});
  assign mapped = hit_ctrl | hit_b2 | hit_sel | hit_sink;
  assign acc = psel & penable & pready;

  // Writes land only at the access edge, and only with the low byte lane strobed
  wire wr_en;
  assign wr_en = acc & pwrite & pstrb[0];

  // Control register
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= `BCT_RST_CTRL;
    else if (wr_en & hit_ctrl)
      ctrl <= pwdata[7:0];
  end

  // Boost settings register: all eight fields move together
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      boost2 <= `BCT_RST_BOOST2;
    else if (wr_en & hit_b2)
      boost2 <= pwdata[7:0];
  end

  // Feedback select register
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sel <= `BCT_RST_SEL;
    else if (wr_en & hit_sel)
      sel <= pwdata[7:0];
  end

  // Sink configuration register
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sink_cfg <= `BCT_RST_SINK;
    else if (wr_en & hit_sink)
      sink_cfg <= pwdata[7:0];
  end

  reg [7:0] rmux;
  always @*
  begin
    rmux = 8'h00;
    if (hit_ctrl)
      rmux = ctrl;
    if (hit_b2)
      rmux = boost2;
    if (hit_sel)
      rmux = sel;
    if (hit_sink)
      rmux = sink_cfg;
  end

  // Ready is registered in setup so it is high in the first access cycle, and the access phase completes in one cycle
  reg next_pready;
  reg next_pslverr;
  reg [31:0] next_prdata;
  always @*
  begin
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = 32'h0;
    if (psel & ~penable)
    begin
      next_pready = 1'b1;
      next_pslverr = ~mapped;
      if (~pwrite)
        next_prdata = {24'h0, rmux};
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= next_pready;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= next_pslverr;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else
      prdata <= next_prdata;
  end

  // ==========================================
  // Per-sink guard and eligibility
  wire [2:0] eligible;
  wire [2:0] pd;
  genvar g;
  generate
    for (g = 0; g < NUM_SINKS; g = g + 1)
    begin : sinks
      bct_sink_guard bct_sink_guard_inst
      (
        .pclk(pclk),
        .presetn(presetn),
        .guard_en(boost2[`BCT_B_GA + g]),
        .boost_en(ctrl[`BCT_B_BOOST_EN]),
        .over_v(ov_s2[g]),
        .mode(sink_mode_field[2*g+1:2*g]),
        .on_pump(sink_on_pump_flag[g]),
        .pull_on(pd[g]),
        .eligible(eligible[g])
      );
    end
  endgenerate

  // ==========================================
  // Feedback source choice; auto takes lowest eligible sink, never the pin
  // Auto pick cannot tell whether a sink is dimmed by external PWM; software
  // must keep auto off then, or the loop may regulate on a chopped sink
  reg [1:0] next_fb;
  always @*
  begin
    next_fb = feedback_source_sel;
    if (auto_feedback_pick)
    begin
      if (eligible[0])
        next_fb = `BCT_FB_A;
      else if (eligible[1])
        next_fb = `BCT_FB_B;
      else if (eligible[2])
        next_fb = `BCT_FB_C;
      else
        next_fb = `BCT_FB_A; // Nothing eligible: hold a sink so the pin stays unused
    end
  end

  wire next_fb_pin;
  assign next_fb_pin = (next_fb == `BCT_FB_PIN);

  // ==========================================
  // Registered outputs; each pin comes straight from its own flip-flop
  // Reset values match the register defaults, so nothing steps on release
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      boost_enable <= 1'b0;
    else
      boost_enable <= ctrl[`BCT_B_BOOST_EN];
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gain_select <= 1'b0;
    else
      gain_select <= boost2[`BCT_B_GAIN];
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      light_load_elevate <= 1'b0;
    else
      light_load_elevate <= boost2[`BCT_B_ELEV];
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      feedback_overvoltage_guard <= 1'b1;
    else
      feedback_overvoltage_guard <= boost2[`BCT_B_FBOV];
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      coil_limit_reduce <= 1'b1;
    else
      coil_limit_reduce <= boost2[`BCT_B_COIL];
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sink_pulldown <= 3'h0;
    else
      sink_pulldown <= pd;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fb_source <= `BCT_FB_PIN;
    else
      fb_source <= next_fb;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fb_from_pin <= 1'b1;
    else
      fb_from_pin <= next_fb_pin;
  end
endmodule // bct_boost_regs

// ===== bct_boost_regs_properties.sv
// Checker for the boost control register bank, bound to its top module.
// Assumes zero-wait APB and byte address = four times the register index.
// ========
// Checker
module bct_boost_regs_properties
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [2:0] sink_over_v,
  input wire boost_enable,
  input wire gain_select,
  input wire light_load_elevate,
  input wire feedback_overvoltage_guard,
  input wire coil_limit_reduce,
  input wire [2:0] sink_pulldown,
  input wire [1:0] fb_source,
  input wire fb_from_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pready && pwrite && pstrb[0];
  wire w2 = wr && paddr == 12'h088;
  AST_READY: assert property (psel && !penable |=> pready) else $error("late");
  AST_GAIN: assert property (w2 |=> ##1 gain_select == $past(pwdata[0], 2)) else $error("gain");
  AST_ELEV: assert property (w2 |=> ##1 light_load_elevate == $past(pwdata[1], 2)) else $error("elev");
  AST_FBOV: assert property (w2 |=> ##1 feedback_overvoltage_guard == $past(pwdata[2], 2)) else $error("fbov");
  AST_COIL: assert property (w2 |=> ##1 coil_limit_reduce == $past(pwdata[3], 2)) else $error("coil");
  AST_BOOST: assert property (wr && paddr == 12'h000 |=> ##1 boost_enable == $past(pwdata[3], 2)) else $error("en");
  AST_AUTO: assert property (w2 && pwdata[7] |=> ##1 !fb_from_pin) else $error("auto");
  AST_PIN: assert property (fb_from_pin |-> fb_source == 2'h0) else $error("pin");
  AST_PD: assert property ($rose(sink_pulldown[0]) |-> $past(sink_over_v[0], 4) && $past(boost_enable)) else $error("pd");
  AST_ERR: assert property (psel && !penable && paddr == 12'h0fc |=> pslverr && prdata == 32'h0) else $error("err");
  cover property (w2 && pwdata[7]);
  cover property (pslverr);
  cover property (sink_pulldown[2]);
endmodule // bct_boost_regs_properties
bind bct_boost_regs bct_boost_regs_properties bct_boost_regs_properties_inst (.*);

// ===== bct_boost_regs_tb.sv
// Self-checking bench for the boost control register bank over APB.
// Assumes a zero-wait slave; read results are matched by a monitor.
// ========
// Bench
module bct_boost_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin num_errors++; $display("BAD %s %h %h", n, e, s); end end
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, boost_enable, gain_select, fb_from_pin;
  logic light_load_elevate, feedback_overvoltage_guard, coil_limit_reduce;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [2:0] sink_over_v, sink_pulldown;
  logic [1:0] fb_source;
  logic [3:0] cfg;
  assign cfg = {coil_limit_reduce, feedback_overvoltage_guard, light_load_elevate, gain_select};
  logic [32:0] q[$];
  logic [32:0] e;
  logic [7:0] v;
  int num_errors = 0;
  int num_checks = 0;
  bct_boost_regs bct_boost_regs_inst (.*);
  initial
  begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  task results;
    if (num_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task xf(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) q.push_back(x);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (!pready && n < 20);
    if (!pready)
    begin
      num_errors++;
      results;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Outputs are looked at mid-cycle so the updates of the last edge have landed
  task look(input logic [5:0] x);
    repeat (2) @(negedge pclk);
    `CHK("outs", x, {sink_pulldown, fb_from_pin, fb_source})
    @(posedge pclk);
  endtask
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
    begin
      e = q.pop_front();
      `CHK("prdata", e, {pslverr, prdata})
    end
  initial
  begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    pstrb = 4'hf;
    sink_over_v = 0;
    void'($urandom(32'h2807));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("rst", 11'h04c, {boost_enable, sink_pulldown, fb_from_pin, fb_source, cfg})
    xf(0, 12'h088, 0, 33'h00c);
    xf(0, 12'h000, 0, 33'h0);
    xf(0, 12'h0fc, 0, {1'b1, 32'h0});
    repeat (8)
    begin
      v = 8'($urandom);
      xf(1, 12'h088, {24'h0, v}, 0);
      xf(0, 12'h088, 0, {25'h0, v});
      `CHK("cfg", v[3:0], cfg)
    end
    pstrb <= 4'h0;
    xf(1, 12'h088, {24'h0, ~v}, 0);
    pstrb <= 4'hf;
    xf(0, 12'h088, 0, {25'h0, v});
    xf(1, 12'h088, 32'h7c, 0);
    for (int c = 0; c < 4; c++)
    begin
      xf(1, 12'h084, 32'(c << 1), 0);
      look({3'b0, c == 0, 2'(c)});
    end
    // Manual choice back on the pin, so only auto can show sink c
    xf(1, 12'h084, 32'h0, 0);
    // Sink b on the pump, so sink c is the only candidate; then b leaves the pump
    xf(1, 12'h0c0, 32'h54, 0);
    xf(1, 12'h088, 32'hfc, 0);
    look(6'h03);
    xf(1, 12'h0c0, 32'h14, 0);
    look(6'h02);
    xf(1, 12'h000, 32'h8, 0);
    sink_over_v <= 3'b101;
    repeat (4) @(posedge pclk);
    look(6'h2a);
    `CHK("boost_enable", 1'b1, boost_enable)
    xf(1, 12'h000, 32'h0, 0);
    repeat (4) @(posedge pclk);
    look(6'h02);
    `CHK("boost_enable", 1'b0, boost_enable)
    results;
  end
endmodule // bct_boost_regs_tb
